// ### console_port_control.sv
`include "cpc_cfg.svh"
module console_port_control #(
    parameter int NPORTS = 8
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // emergency character sink
    output logic      [7:0]  urgentChar,
    output logic             urgentValid,
    // configuration change notice
    output logic             cfgChange,
    // device-to-driver control message stream (control receive queue)
    output logic      [31:0] ctlRxWord,
    output logic             ctlRxValid,
    input  wire logic        ctlRxReady,
    // driver-to-device control message (control transmit queue)
    input  wire logic [31:0] ctlTxPort,
    input  wire logic [15:0] ctlTxEvent,
    input  wire logic [15:0] ctlTxValue,
    input  wire logic        ctlTxValid,
    output logic             ctlTxReady,
    // queue existence, bit per queue index
    output logic      [2*NPORTS+1:0] queueEnable
);
    // ****************************************
    // reset release
    // ****************************************
    // async assert, release after two edges so every flop leaves reset together
    logic [1:0] rstSync_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    wire rstN = rstSync_q[1];

    // ****************************************
    // bus decode
    // ****************************************
    // strobes valid only in the access phase of a transfer
    wire wrEn  = psel & penable & pwrite;
    wire rdEn  = psel & penable & ~pwrite;
    wire hitSize    = (paddr == `CPC_OFF_SIZE);
    wire hitPortLim = (paddr == `CPC_OFF_PORTLIM);
    wire hitUrgent  = (paddr == `CPC_OFF_URGENT);
    wire hitFeat    = (paddr == `CPC_OFF_FEATURES);
    wire hitCtrl    = (paddr == `CPC_OFF_CTRL);
    wire hitSetSize = (paddr == `CPC_OFF_SETSIZE);
    wire hitDevMsg  = (paddr == `CPC_OFF_DEVMSG);
    wire hitStatus  = (paddr == `CPC_OFF_STATUS);
    wire hitPortMap = (paddr == `CPC_OFF_PORTMAP);
    wire hitOpenMap = (paddr == `CPC_OFF_OPENMAP);
    wire hitRdyMap  = (paddr == `CPC_OFF_READYMAP);
    wire hitDrvMsg  = (paddr == `CPC_OFF_DRVMSG);
    wire hitQueues  = (paddr == `CPC_OFF_QUEUES);
    wire anyHit = hitSize | hitPortLim | hitUrgent | hitFeat | hitCtrl | hitSetSize | hitDevMsg
                | hitStatus | hitPortMap | hitOpenMap | hitRdyMap | hitDrvMsg | hitQueues;

    // ****************************************
    // configuration state
    // ****************************************
    logic [31:0] feat_q;
    logic [1:0]  ctrl_q;
    logic [15:0] cols_q;
    logic [15:0] lines_q;
    logic [NPORTS-1:0] portMap_q;
    logic [NPORTS-1:0] openMap_q;
    logic [NPORTS-1:0] readyMap_q;
    logic        drvReady_q;
    logic [31:0] drvMsg_q;
    logic        drvMsgNew_q;
    logic [7:0]  dropCnt_q;
    logic [7:0]  urgentChar_q;
    logic        urgentValid_q;
    logic        cfgChange_q;

    wire featSize  = feat_q[`CPC_FEAT_SIZE];
    wire featMulti = feat_q[`CPC_FEAT_MULTI];
    wire legacy    = ctrl_q[`CPC_CTRL_LEGACY];
    wire bigEnd    = ctrl_q[`CPC_CTRL_BIGEND];

    // ****************************************
    // feature and control registers
    // ****************************************
    // features are masked to the offered set; other written bits are lost
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            feat_q <= `CPC_RST_FEATURES;
            ctrl_q <= 2'h0;
        end else begin
            if (wrEn && hitFeat) feat_q <= pwdata & `CPC_RST_FEATURES;
            if (wrEn && hitCtrl) ctrl_q <= pwdata[1:0];
        end
    end

    // urgent write needs no setup or features; low byte to sink
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            urgentChar_q  <= 8'h00;
            urgentValid_q <= 1'b0;
        end else begin
            urgentValid_q <= wrEn && hitUrgent;
            if (wrEn && hitUrgent) urgentChar_q <= pwdata[7:0];
        end
    end
    assign urgentChar  = urgentChar_q;
    assign urgentValid = urgentValid_q;

    // console size; notice only when size feature negotiated, applies to port 0
    wire sizeWr = wrEn && hitSetSize;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cols_q      <= `CPC_RST_COLS;
            lines_q     <= `CPC_RST_LINES;
            cfgChange_q <= 1'b0;
        end else begin
            cfgChange_q <= sizeWr && featSize;
            if (sizeWr) begin
                cols_q  <= pwdata[15:0];
                lines_q <= pwdata[31:16];
            end
        end
    end
    assign cfgChange = cfgChange_q;

    // ****************************************
    // device-to-driver message sender
    // ****************************************
    // message request word from software: [7:0] port, [10:8] event code,
    // [16] open state value; other events carry a zero value
    // resize messages take the console size as a third word, so the driver
    // sees the dimensions that stood when the request was taken
    cpc_pkg::cpc_send_e state_q;
    logic [31:0] sPort_q;
    logic [15:0] sEvent_q;
    logic [15:0] sValue_q;
    logic [31:0] sTail_q;
    logic        sHasTail_q;
    logic        refused_q;

    wire [7:0]  reqPort  = pwdata[7:0];
    wire [15:0] reqEvent = {13'h0000, pwdata[10:8]};
    wire        reqInRange = ({24'h000000, reqPort} < 32'(NPORTS));
    wire        reqExists  = reqInRange && portMap_q[reqPort[$clog2(NPORTS)-1:0]];
    // adds of existing or out-of-range ports and removes of unknown ports refused
    // driver-only events (ready, port ready) are never sent by the device
    wire reqBad = ((reqEvent == `CPC_EV_ADD) && (!reqInRange || reqExists))
                || ((reqEvent != `CPC_EV_ADD) && !reqExists)
                || (reqEvent == `CPC_EV_DRV_READY) || (reqEvent == `CPC_EV_PORT_READY);
    wire sendIdle = (state_q == cpc_pkg::SEND_IDLE);
    wire msgWr    = wrEn && hitDevMsg;
    // control receive queue only when multiport negotiated and driver ready
    wire msgTake  = msgWr && sendIdle && featMulti && drvReady_q && !reqBad;

    wire [31:0] hdWord0, hdWord1;
    cpc_byte_order uOrd0 (
        .legacy  (legacy),
        .bigEnd  (bigEnd),
        .half    (1'b0),
        .inWord  (sPort_q),
        .outWord (hdWord0)
    );
    cpc_byte_order uOrd1 (
        .legacy  (legacy),
        .bigEnd  (bigEnd),
        .half    (1'b1),
        .inWord  (state_q == cpc_pkg::SEND_TAIL ? sTail_q : {sValue_q, sEvent_q}),
        .outWord (hdWord1)
    );

    logic headHalf_q;
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_q    <= cpc_pkg::SEND_IDLE;
            sPort_q    <= 32'h0000_0000;
            sEvent_q   <= 16'h0000;
            sValue_q   <= 16'h0000;
            sTail_q    <= 32'h0000_0000;
            sHasTail_q <= 1'b0;
            headHalf_q <= 1'b0;
            refused_q  <= 1'b0;
        end else begin
            if (msgWr) refused_q <= !msgTake;
            case (state_q)
                cpc_pkg::SEND_IDLE: begin
                    headHalf_q <= 1'b0;
                    if (msgTake) begin
                        sPort_q    <= {24'h000000, reqPort};
                        sEvent_q   <= reqEvent;
                        sValue_q   <= (reqEvent == `CPC_EV_OPEN) ? {15'h0000, pwdata[16]} : 16'h0000;
                        sTail_q    <= {lines_q, cols_q};
                        sHasTail_q <= (reqEvent == `CPC_EV_RESIZE);
                        state_q    <= cpc_pkg::SEND_HEAD;
                    end
                end
                cpc_pkg::SEND_HEAD: begin
                    if (ctlRxReady) begin
                        headHalf_q <= ~headHalf_q;
                        if (headHalf_q) begin
                            state_q <= sHasTail_q ? cpc_pkg::SEND_TAIL : cpc_pkg::SEND_IDLE;
                        end
                    end
                end
                cpc_pkg::SEND_TAIL: begin
                    if (ctlRxReady) state_q <= cpc_pkg::SEND_IDLE;
                end
                default: state_q <= cpc_pkg::SEND_IDLE;
            endcase
        end
    end
    // name bytes follow via software-driven stream outside this block
    assign ctlRxValid = !sendIdle;
    assign ctlRxWord  = (state_q == cpc_pkg::SEND_HEAD && !headHalf_q) ? hdWord0 : hdWord1;

    // ****************************************
    // port tracking and driver messages
    // ****************************************
    wire [$clog2(NPORTS)-1:0] sIdx = sPort_q[$clog2(NPORTS)-1:0];
    wire msgDone = (state_q == cpc_pkg::SEND_HEAD) && headHalf_q && ctlRxReady;
    wire txInRange = (ctlTxPort < 32'(NPORTS));
    wire [$clog2(NPORTS)-1:0] tIdx = ctlTxPort[$clog2(NPORTS)-1:0];
    wire txKnown   = txInRange && portMap_q[tIdx];
    wire txIsReady = (ctlTxEvent == `CPC_EV_DRV_READY);
    wire txIsPort  = (ctlTxEvent == `CPC_EV_PORT_READY) || (ctlTxEvent == `CPC_EV_OPEN);
    wire txAccept  = ctlTxValid && featMulti && (txIsReady || (txIsPort && txKnown));
    // driver messages are taken in one cycle, so no back pressure is needed
    assign ctlTxReady = 1'b1;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            portMap_q   <= '0;
            openMap_q   <= '0;
            readyMap_q  <= '0;
            drvReady_q  <= 1'b0;
            drvMsg_q    <= 32'h0000_0000;
            drvMsgNew_q <= 1'b0;
            dropCnt_q   <= 8'h00;
        end else begin
            if (msgDone && sEvent_q == `CPC_EV_ADD) portMap_q[sIdx] <= 1'b1;
            if (msgDone && sEvent_q == `CPC_EV_REMOVE) begin
                portMap_q[sIdx]  <= 1'b0;
                openMap_q[sIdx]  <= 1'b0;
                readyMap_q[sIdx] <= 1'b0;
            end
            if (txAccept && txIsReady) drvReady_q <= ctlTxValue[0];
            if (txAccept && ctlTxEvent == `CPC_EV_PORT_READY) readyMap_q[tIdx] <= ctlTxValue[0];
            if (txAccept && ctlTxEvent == `CPC_EV_OPEN) openMap_q[tIdx] <= ctlTxValue[0];
            if (ctlTxValid && !txAccept) dropCnt_q <= dropCnt_q + 8'h01;
            // new message wins over software clear in the same cycle
            if (txAccept) begin
                drvMsg_q    <= {ctlTxValue, ctlTxEvent[7:0], ctlTxPort[7:0]};
                drvMsgNew_q <= 1'b1;
            end else if (rdEn && hitDrvMsg) begin
                drvMsgNew_q <= 1'b0;
            end
        end
    end

    // receive/transmit of port 0 always; rest only with multiport
    // enables follow the acknowledged feature word, so they drop when it is cleared
    genvar gq;
    generate
        for (gq = 0; gq < 2 * NPORTS + 2; gq++) begin : gQueue
            if (gq < 2) begin : gBase
                assign queueEnable[gq] = 1'b1;
            end else begin : gMulti
                assign queueEnable[gq] = featMulti;
            end
        end
    endgenerate

    // ****************************************
    // read path
    // ****************************************
    wire [31:0] cfgSize, cfgLim;
    cpc_byte_order uOrdSize (
        .legacy  (legacy),
        .bigEnd  (bigEnd),
        .half    (1'b1),
        .inWord  ({lines_q, cols_q}),
        .outWord (cfgSize)
    );
    cpc_byte_order uOrdLim (
        .legacy  (legacy),
        .bigEnd  (bigEnd),
        .half    (1'b0),
        .inWord  (32'(NPORTS)),
        .outWord (cfgLim)
    );
    wire [31:0] statusWord = {16'h0000, dropCnt_q, 4'h0, refused_q, drvMsgNew_q, drvReady_q, !sendIdle};
    // read mux; unmapped offsets read zero and raise the error response
    wire [31:0] rdMux =
        hitSize    ? cfgSize :
        hitPortLim ? cfgLim :
        hitFeat    ? feat_q :
        hitCtrl    ? {30'h0, ctrl_q} :
        hitSetSize ? {lines_q, cols_q} :
        hitStatus  ? statusWord :
        hitPortMap ? 32'(portMap_q) :
        hitOpenMap ? 32'(openMap_q) :
        hitRdyMap  ? 32'(readyMap_q) :
        hitDrvMsg  ? drvMsg_q :
        hitQueues  ? 32'(queueEnable) : 32'h0000_0000; // urgent field is write only
    assign prdata  = rdEn ? rdMux : 32'h0000_0000;
    // zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & !anyHit;
endmodule

// ### cpc_byte_order.sv
// ****************************************
// field byte swap for legacy guest order
// ****************************************
module cpc_byte_order (
    input  wire logic        legacy,
    input  wire logic        bigEnd,
    input  wire logic        half,
    input  wire logic [31:0] inWord,
    output logic      [31:0] outWord
);
    // swap only when legacy mode and the guest is big endian
    wire        doSwap  = legacy & bigEnd;
    wire [31:0] swap32  = {inWord[7:0], inWord[15:8], inWord[23:16], inWord[31:24]};
    wire [31:0] swap16  = {inWord[23:16], inWord[31:24], inWord[7:0], inWord[15:8]};
    assign outWord = !doSwap ? inWord : (half ? swap16 : swap32);
endmodule

// ### cpc_cfg.svh
`ifndef CPC_CFG_SVH
`define CPC_CFG_SVH
// ****************************************
// register byte offsets
// ****************************************
`define CPC_OFF_SIZE      12'h000
`define CPC_OFF_PORTLIM   12'h004
`define CPC_OFF_URGENT    12'h008
`define CPC_OFF_FEATURES  12'h00C
`define CPC_OFF_CTRL      12'h010
`define CPC_OFF_SETSIZE   12'h014
`define CPC_OFF_DEVMSG    12'h018
`define CPC_OFF_STATUS    12'h01C
`define CPC_OFF_PORTMAP   12'h020
`define CPC_OFF_OPENMAP   12'h024
`define CPC_OFF_READYMAP  12'h028
`define CPC_OFF_DRVMSG    12'h02C
`define CPC_OFF_QUEUES    12'h030
// ****************************************
// feature bits and control fields
// ****************************************
`define CPC_FEAT_SIZE     0
`define CPC_FEAT_MULTI    1
`define CPC_FEAT_URGENT   2
`define CPC_CTRL_LEGACY   0
`define CPC_CTRL_BIGEND   1
`define CPC_RST_FEATURES  32'h0000_0007
`define CPC_RST_COLS      16'h0050
`define CPC_RST_LINES     16'h0018
// ****************************************
// control message event codes
// ****************************************
`define CPC_EV_DRV_READY  16'h0000
`define CPC_EV_ADD        16'h0001
`define CPC_EV_REMOVE     16'h0002
`define CPC_EV_PORT_READY 16'h0003
`define CPC_EV_CONSOLE    16'h0004
`define CPC_EV_RESIZE     16'h0005
`define CPC_EV_OPEN       16'h0006
`define CPC_EV_NAME       16'h0007
`endif

// ### cpc_drv_model.sv
// ****
// guest driver on the control queues
// ****
module cpc_drv_model (
    input  wire logic        clk,
    input  wire logic [31:0] ctlRxWord,
    input  wire logic        ctlRxValid,
    output logic             ctlRxReady,
    output logic      [31:0] ctlTxPort,
    output logic      [15:0] ctlTxEvent,
    output logic      [15:0] ctlTxValue,
    output logic             ctlTxValid,
    input  wire logic        ctlTxReady
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        slow = 1'b0;
    logic [31:0] rxQ[$];
    logic [31:0] msg[$];
    logic [63:0] txQ[$];
    initial begin
        ctlRxReady = 1'b1;
        ctlTxValid = 1'b0;
        {ctlTxPort, ctlTxEvent, ctlTxValue} = '0;
    end
    // one message at a time; released lines show the inverse, not the old value
    always @(posedge clk) begin
        if (ctlTxValid && ctlTxReady) begin
            void'(txQ.pop_front());
            ctlTxValid <= 1'b0;
            {ctlTxPort, ctlTxEvent, ctlTxValue} <= ~{ctlTxPort, ctlTxEvent, ctlTxValue};
        end else if (!ctlTxValid && txQ.size() > 0) begin
            {ctlTxPort, ctlTxEvent, ctlTxValue} <= txQ[0];
            ctlTxValid <= 1'b1;
        end
    end
    // gather device messages; a slow driver takes a word every other cycle
    always @(posedge clk) begin
        ctlRxReady <= slow ? ~ctlRxReady : 1'b1;
        if (ctlRxValid && ctlRxReady) begin
            msg.push_back(ctlRxWord);
            if (msg.size() == 3 || (msg.size() == 2 && msg[1][15:0] != 16'h0005)) begin
                if (msg[1][15:0] == 16'h0001) txQ.push_back({msg[0], 16'h0003, 16'h0001});
                if (msg[1][15:0] == 16'h0004) txQ.push_back({msg[0], 16'h0006, 16'h0001});
                rxQ = {rxQ, msg};
                msg.delete();
            end
        end
    end
endmodule

// ### cpc_pkg.sv
package cpc_pkg;
    // states of the device-to-driver message sender
    typedef enum logic [1:0] {
        SEND_IDLE,
        SEND_HEAD,
        SEND_TAIL
    } cpc_send_e;
    typedef logic [31:0] cpc_word_t;
endpackage

// ### cpc_props.sv
`include "cpc_cfg.svh"
// ****
// console port checker
// ****
module cpc_props #(
    parameter int NPORTS = 8
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  urgentChar,
    input wire logic        urgentValid,
    input wire logic        cfgChange,
    input wire logic [31:0] ctlRxWord,
    input wire logic        ctlRxValid,
    input wire logic        ctlRxReady,
    input wire logic        ctlTxValid,
    input wire logic        ctlTxReady,
    input wire logic [2*NPORTS+1:0] queueEnable
);
    logic featSize_q;
    // decoded write strobes at the access edge
    wire  accWr  = psel && penable && pwrite;
    wire  urgWr  = accWr && paddr == `CPC_OFF_URGENT;
    wire  featWr = accWr && paddr == `CPC_OFF_FEATURES;
    wire  sizeWr = accWr && paddr == `CPC_OFF_SETSIZE && featSize_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // shadow of the size feature, offered from reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) featSize_q <= 1'b1;
        else if (featWr) featSize_q <= pwdata[`CPC_FEAT_SIZE];
    end
    // driver holding back a stream word
    sequence s_rxStall;
        ctlRxValid && !ctlRxReady;
    endsequence
    chk_zero_wait: assert property (psel && penable |-> pready)
        else $error("access not answered at once");
    chk_unmapped_err: assert property (psel && penable && paddr > 12'h030 |-> pslverr)
        else $error("unmapped access without error");
    chk_urgent_byte: assert property (
        urgWr |=> urgentValid && urgentChar == $past(pwdata[7:0]))
        else $error("urgent byte not forwarded");
    chk_urgent_cause: assert property (urgentValid |-> $past(urgWr))
        else $error("urgent strobe without write");
    chk_size_notice: assert property (sizeWr |=> cfgChange)
        else $error("size change without notice");
    chk_notice_cause: assert property (cfgChange |-> $past(sizeWr))
        else $error("notice without size change");
    chk_base_queues: assert property (queueEnable[1:0] == 2'b11)
        else $error("port 0 queues missing");
    chk_multi_queues: assert property (
        featWr |=> queueEnable[2*NPORTS+1:2] == {(2*NPORTS){$past(pwdata[1])}})
        else $error("queues do not follow multiport");
    chk_rx_hold: assert property (s_rxStall |=> ctlRxValid && $stable(ctlRxWord))
        else $error("stream word lost while stalled");
    chk_tx_take: assert property (ctlTxValid |-> ctlTxReady)
        else $error("driver message not taken");
endmodule

bind console_port_control cpc_props #(.NPORTS(NPORTS)) u_props (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .urgentChar(urgentChar), .urgentValid(urgentValid), .cfgChange(cfgChange),
    .ctlRxWord(ctlRxWord), .ctlRxValid(ctlRxValid), .ctlRxReady(ctlRxReady),
    .ctlTxValid(ctlTxValid), .ctlTxReady(ctlTxReady), .queueEnable(queueEnable));

// ### tb.sv
`include "cpc_cfg.svh"
// ****
// console port bench
// ****
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] allBits = 32'hFFFF_FFFF;
    localparam logic [31:0] sizeB = 32'h001E_0064;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rdat, ctlRxWord, ctlTxPort;
    logic [15:0] ctlTxEvent, ctlTxValue;
    logic [17:0] queueEnable;
    logic [7:0]  urgentChar;
    logic        pready, pslverr, rerr, rrdy, urgentValid, cfgChange;
    logic        ctlRxValid, ctlRxReady, ctlTxValid, ctlTxReady;
    int          errCount = 0;
    int          compares = 0;
    int          cycles = 0;
    // bad, value, event, port of each device message
    logic [12:0] tbl [9] = '{13'h0101, 13'h1101, 13'h1108, 13'h1205, 13'h0401,
                             13'h0E01, 13'h0701, 13'h0501, 13'h0201};

    console_port_control #(.NPORTS(8)) u_dut (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .urgentChar(urgentChar), .urgentValid(urgentValid), .cfgChange(cfgChange),
        .ctlRxWord(ctlRxWord), .ctlRxValid(ctlRxValid), .ctlRxReady(ctlRxReady),
        .ctlTxPort(ctlTxPort), .ctlTxEvent(ctlTxEvent), .ctlTxValue(ctlTxValue),
        .ctlTxValid(ctlTxValid), .ctlTxReady(ctlTxReady), .queueEnable(queueEnable));
    cpc_drv_model u_drv (
        .clk(clk), .ctlRxWord(ctlRxWord), .ctlRxValid(ctlRxValid), .ctlRxReady(ctlRxReady),
        .ctlTxPort(ctlTxPort), .ctlTxEvent(ctlTxEvent), .ctlTxValue(ctlTxValue),
        .ctlTxValid(ctlTxValid), .ctlTxReady(ctlTxReady));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; an idle edge first, the answer taken at the ready edge
    task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            {rrdy, rerr, rdat} = {pready, pslverr, prdata};
        end while (rrdy !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // polls a masked register until it matches or gives up
    task automatic read_check(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        do begin
            apb_xfer(1'b0, a, 32'h0000_0000);
            n++;
        end while ((rdat & m) !== e && n < 40);
        check(rdat & m, e);
    endtask
    // device message, then the refused flag and the words the driver saw
    task automatic dev_msg(input logic [12:0] e);
        apb_xfer(1'b1, `CPC_OFF_DEVMSG, {15'h0000, e[11], 5'h00, e[10:0]});
        read_check(`CPC_OFF_STATUS, 32'h0000_0009, {28'h0000000, e[12], 3'h0});
        if (!e[12]) begin
            check(u_drv.rxQ.pop_front(), {24'h000000, e[7:0]});
            check(u_drv.rxQ.pop_front(), {15'h0000, e[11], 13'h0000, e[10:8]});
            if (e[10:8] == 3'h5) check(u_drv.rxQ.pop_front(), sizeB);
        end
        check(u_drv.rxQ.size(), 32'h0000_0000);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        forever #25 clk = ~clk;
    end
    // hang guard, far above the 150 or so cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            final_report();
        end
    end
    // main sequence: reset, then calls with expected values
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
        apb_xfer(1'b1, `CPC_OFF_URGENT, 32'h1234_56A5);
        @(negedge clk);
        check(urgentChar, 32'h0000_00A5);
        check(urgentValid, 32'h0000_0001);
        @(posedge clk);
        read_check(`CPC_OFF_FEATURES, allBits, 32'h0000_0007);
        read_check(`CPC_OFF_PORTLIM, allBits, 32'h0000_0008);
        read_check(`CPC_OFF_SIZE, allBits, 32'h0018_0050);
        read_check(`CPC_OFF_QUEUES, allBits, 32'h0003_FFFF);
        apb_xfer(1'b0, 12'h040, 32'h0000_0000);
        check(rerr, 32'h0000_0001);
        apb_xfer(1'b1, `CPC_OFF_FEATURES, 32'h0000_0004);
        read_check(`CPC_OFF_QUEUES, allBits, 32'h0000_0003);
        apb_xfer(1'b1, `CPC_OFF_SETSIZE, 32'h0019_0050);
        @(negedge clk);
        check(cfgChange, 32'h0000_0000);
        dev_msg(13'h1101);
        apb_xfer(1'b1, `CPC_OFF_FEATURES, 32'h0000_0007);
        apb_xfer(1'b1, `CPC_OFF_SETSIZE, sizeB);
        @(negedge clk);
        check(cfgChange, 32'h0000_0001);
        read_check(`CPC_OFF_SIZE, allBits, sizeB);
        apb_xfer(1'b1, `CPC_OFF_CTRL, 32'h0000_0003);
        read_check(`CPC_OFF_PORTLIM, allBits, 32'h0800_0000);
        apb_xfer(1'b1, `CPC_OFF_CTRL, 32'h0000_0000);
        dev_msg(13'h1101);
        u_drv.txQ.push_back({32'h0000_0000, 16'h0000, 16'h0001});
        read_check(`CPC_OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
        for (int i = 0; i < 9; i++) begin
            u_drv.slow = i[0];
            dev_msg(tbl[i]);
            if (i == 0) read_check(`CPC_OFF_READYMAP, 32'h0000_0002, 32'h0000_0002);
            if (i == 4) read_check(`CPC_OFF_OPENMAP, 32'h0000_0002, 32'h0000_0002);
            if (i == 4) read_check(`CPC_OFF_DRVMSG, allBits, 32'h0001_0601);
        end
        read_check(`CPC_OFF_PORTMAP, 32'h0000_0002, 32'h0000_0000);
        u_drv.txQ.push_back({32'h0000_0001, 16'h0009, 16'h0000});
        u_drv.txQ.push_back({32'h0000_0006, 16'h0003, 16'h0001});
        read_check(`CPC_OFF_STATUS, 32'h0000_FF00, 32'h0000_0200);
        final_report();
    end
endmodule
